// *** src/pbamux_params.svh ***
`ifndef PBAMUX_PARAMS_SVH
`define PBAMUX_PARAMS_SVH
// Pin positions within port B
`define PBAMUX_PIN_SCK      3'h7
`define PBAMUX_PIN_MISO     3'h6
`define PBAMUX_PIN_MOSI     3'h5
`define PBAMUX_PIN_SSEL     3'h4
`define PBAMUX_PIN_CMP0A    3'h3
`define PBAMUX_PIN_IRQ2     3'h2
`define PBAMUX_PIN_DIVIDED_CLOCK_OUT     3'h1
`define PBAMUX_PIN_XCK      3'h0
// Pin-change source number of pin 0
`define PBAMUX_PCSRC_BASE   8'h08
// Reset values
`define PBAMUX_RST_PIN_OUT  8'h00
`define PBAMUX_RST_PIN_OE   8'h00
`endif

// *** src/pbamux_pin_cell.sv ***
`timescale 1ns/10ps
// One port pin: resolves overrides into driver, pull-up and input enable
module pbamux_pin_cell (
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  dirBit,
   input  wire logic                  outBit,
   input  wire logic                  pullupGlobalDisable,
   input  wire logic                  sleepInputDisable,
   input  wire pbamux_pkg::pbamux_ovr_t ovr,
   input  wire logic                  padIn,
   output logic                       padOut,
   output logic                       padOe,
   output logic                       pullupOn,
   output logic                       inputEnable,
   output logic                       syncIn
);
   import pbamux_pkg::*;
   logic padMeta_ff;
   logic padSync_ff;
   logic nxt_padOut;
   logic nxt_padOe;
   assign nxt_padOe = ovr.dirOvrEn ? ovr.dirOvrVal : dirBit;
   assign nxt_padOut = ovr.valOvrEn ? ovr.valOvrVal : outBit;
   assign pullupOn = ovr.pullupOvrEn ? ovr.pullupOvrVal
                   : (outBit & ~nxt_padOe & ~pullupGlobalDisable);
   assign inputEnable = ovr.inEnOvrEn ? ovr.inEnOvrVal : ~sleepInputDisable;
   // Registered pad drive
   always_ff @(posedge clk) begin
      if (rst) begin
         padOut <= 1'b0;
         padOe  <= 1'b0;
      end else begin
         padOut <= nxt_padOut;
         padOe  <= nxt_padOe;
      end
   end
   // Two-flop pad synchroniser
   always_ff @(posedge clk) begin
      if (rst) begin
         padMeta_ff <= 1'b0;
         padSync_ff <= 1'b0;
      end else begin
         padMeta_ff <= padIn;
         padSync_ff <= padMeta_ff;
      end
   end
   // Input buffer gate, after the raw pad has passed both flops
   assign syncIn = padSync_ff & inputEnable;
endmodule

// *** src/pbamux_pkg.sv ***
package pbamux_pkg;
   // Per-pin override bundle
   typedef struct packed {
      logic pullupOvrEn;
      logic pullupOvrVal;
      logic dirOvrEn;
      logic dirOvrVal;
      logic valOvrEn;
      logic valOvrVal;
      logic inEnOvrEn;
      logic inEnOvrVal;
   } pbamux_ovr_t;
   // Serial interface role
   typedef enum logic [2:0] {
      PBAMUX_SPI_OFF    = 3'b001,
      PBAMUX_SPI_SLAVE  = 3'b010,
      PBAMUX_SPI_MASTER = 3'b100
   } pbamux_spi_t;
endpackage

// *** src/pbamux_port_b.sv ***
`timescale 1ns/10ps
`include "pbamux_params.svh"
module pbamux_port_b (
   clk,
   rst,
   dirBits,
   outBits,
   pullupGlobalDisable,
   sleepInputDisable,
   serialIfEnable,
   serialIfMasterSel,
   sckOut,
   spiSlaveDataOut,
   spiMasterDataOut,
   timer3CmpBOut,
   timer3CmpBEnable,
   timer3CmpAOut,
   timer3CmpAEnable,
   timer0CmpBOut,
   timer0CmpBEnable,
   timer0CmpAOut,
   timer0CmpAEnable,
   extIrq2Enable,
   pinChangeMask,
   pinChangeGroup1En,
   clockOutFuse,
   dividedClock,
   usart0SyncMode,
   usart0ClockOut,
   padIn,
   padOut,
   padOe,
   pullupOn,
   inputEnable,
   pinIn,
   sckIn,
   spiMasterDataIn,
   spiSlaveDataIn,
   spiSlaveSelected,
   spiMode,
   timer3CaptureIn,
   extIrq2In,
   timer1CountIn,
   timer0CountIn,
   usart0ExtClockIn,
   usart0ClockDrive,
   pinChangeSrc
);
   import pbamux_pkg::*;
   input  wire logic        clk;
   input  wire logic        rst;
   input  wire logic [7:0]  dirBits;
   input  wire logic [7:0]  outBits;
   input  wire logic        pullupGlobalDisable;
   input  wire logic        sleepInputDisable;
   input  wire logic        serialIfEnable;
   input  wire logic        serialIfMasterSel;
   input  wire logic        sckOut;
   input  wire logic        spiSlaveDataOut;
   input  wire logic        spiMasterDataOut;
   input  wire logic        timer3CmpBOut;
   input  wire logic        timer3CmpBEnable;
   input  wire logic        timer3CmpAOut;
   input  wire logic        timer3CmpAEnable;
   input  wire logic        timer0CmpBOut;
   input  wire logic        timer0CmpBEnable;
   input  wire logic        timer0CmpAOut;
   input  wire logic        timer0CmpAEnable;
   input  wire logic        extIrq2Enable;
   input  wire logic [7:0]  pinChangeMask;
   input  wire logic        pinChangeGroup1En;
   input  wire logic        clockOutFuse;
   input  wire logic        dividedClock;
   input  wire logic        usart0SyncMode;
   input  wire logic        usart0ClockOut;
   input  wire logic [7:0]  padIn;
   output logic [7:0]       padOut;
   output logic [7:0]       padOe;
   output logic [7:0]       pullupOn;
   output logic [7:0]       inputEnable;
   output logic [7:0]       pinIn;
   output logic             sckIn;
   output logic             spiMasterDataIn;
   output logic             spiSlaveDataIn;
   output logic             spiSlaveSelected;
   output pbamux_spi_t      spiMode;
   output logic             timer3CaptureIn;
   output logic             extIrq2In;
   output logic             timer1CountIn;
   output logic             timer0CountIn;
   output logic             usart0ExtClockIn;
   output logic             usart0ClockDrive;
   output logic [15:8]      pinChangeSrc;

   pbamux_ovr_t ovr [7:0];
   pbamux_spi_t spiMode_ff;
   pbamux_spi_t nxt_spiMode;
   logic        spiSlave;
   logic        spiMaster;
   logic [7:0]  cellOut;
   logic [7:0]  cellOe;
   logic [7:0]  syncIn;
   logic        clkoActive;
   logic        slaveSel_ff;

   // Role decode
   always_comb begin
      nxt_spiMode = PBAMUX_SPI_OFF;
      if (serialIfEnable) begin
         nxt_spiMode = serialIfMasterSel ? PBAMUX_SPI_MASTER : PBAMUX_SPI_SLAVE;
      end
   end

   // Role register
   always_ff @(posedge clk) begin
      if (rst) begin
         spiMode_ff <= PBAMUX_SPI_OFF;
      end else begin
         spiMode_ff <= nxt_spiMode;
      end
   end
   assign spiMode = spiMode_ff;

   // Role flags from the state
   always_comb begin
      spiSlave  = 1'b0;
      spiMaster = 1'b0;
      case (spiMode_ff)
         PBAMUX_SPI_SLAVE:  spiSlave = 1'b1;
         PBAMUX_SPI_MASTER: spiMaster = 1'b1;
         PBAMUX_SPI_OFF:    spiSlave = 1'b0;
         default:           spiSlave = 1'b0;
      endcase
   end

   // Override table for the eight pins
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         ovr[i] = '0;
         ovr[i].inEnOvrEn  = pinChangeMask[i] & pinChangeGroup1En;
         ovr[i].inEnOvrVal = 1'b1;
      end
      ovr[`PBAMUX_PIN_SCK].dirOvrEn = spiSlave;
      ovr[`PBAMUX_PIN_SCK].pullupOvrEn  = spiSlave;
      ovr[`PBAMUX_PIN_SCK].pullupOvrVal = outBits[7] & ~pullupGlobalDisable;
      ovr[`PBAMUX_PIN_SCK].valOvrEn  = spiMaster | timer3CmpBEnable;
      ovr[`PBAMUX_PIN_SCK].valOvrVal = spiMaster ? sckOut : timer3CmpBOut;
      ovr[`PBAMUX_PIN_MISO].dirOvrEn = spiMaster;
      ovr[`PBAMUX_PIN_MISO].pullupOvrEn  = spiMaster;
      ovr[`PBAMUX_PIN_MISO].pullupOvrVal = outBits[6] & ~pullupGlobalDisable;
      ovr[`PBAMUX_PIN_MISO].valOvrEn  = spiSlave | timer3CmpAEnable;
      ovr[`PBAMUX_PIN_MISO].valOvrVal = spiSlave ? spiSlaveDataOut : timer3CmpAOut;
      ovr[`PBAMUX_PIN_MOSI].dirOvrEn = spiSlave;
      ovr[`PBAMUX_PIN_MOSI].pullupOvrEn  = spiSlave;
      ovr[`PBAMUX_PIN_MOSI].pullupOvrVal = outBits[5] & ~pullupGlobalDisable;
      ovr[`PBAMUX_PIN_MOSI].valOvrEn  = spiMaster;
      ovr[`PBAMUX_PIN_MOSI].valOvrVal = spiMasterDataOut;
      ovr[`PBAMUX_PIN_SSEL].dirOvrEn = spiSlave;
      ovr[`PBAMUX_PIN_SSEL].pullupOvrEn  = spiSlave;
      ovr[`PBAMUX_PIN_SSEL].pullupOvrVal = outBits[4] & ~pullupGlobalDisable;
      ovr[`PBAMUX_PIN_SSEL].valOvrEn  = timer0CmpBEnable;
      ovr[`PBAMUX_PIN_SSEL].valOvrVal = timer0CmpBOut;
      ovr[`PBAMUX_PIN_CMP0A].valOvrEn  = timer0CmpAEnable;
      ovr[`PBAMUX_PIN_CMP0A].valOvrVal = timer0CmpAOut;
      ovr[`PBAMUX_PIN_IRQ2].inEnOvrEn = extIrq2Enable | ovr[`PBAMUX_PIN_IRQ2].inEnOvrEn;
      ovr[`PBAMUX_PIN_DIVIDED_CLOCK_OUT].dirOvrEn  = clockOutFuse;
      ovr[`PBAMUX_PIN_DIVIDED_CLOCK_OUT].dirOvrVal = clockOutFuse;
      ovr[`PBAMUX_PIN_DIVIDED_CLOCK_OUT].valOvrEn  = clockOutFuse;
      ovr[`PBAMUX_PIN_DIVIDED_CLOCK_OUT].valOvrVal = dividedClock;
      // USART clock drives in sync mode when direction set
      ovr[`PBAMUX_PIN_XCK].valOvrEn  = usart0SyncMode & dirBits[0];
      ovr[`PBAMUX_PIN_XCK].valOvrVal = usart0ClockOut;
   end

   // Per-pin resolution cells
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : gPin
         pbamux_pin_cell uCell (
            .clk                 (clk),
            .rst                 (rst),
            .dirBit              (dirBits[g]),
            .outBit              (outBits[g]),
            .pullupGlobalDisable (pullupGlobalDisable),
            .sleepInputDisable   (sleepInputDisable),
            .ovr                 (ovr[g]),
            .padIn               (padIn[g]),
            .padOut              (cellOut[g]),
            .padOe               (cellOe[g]),
            .pullupOn            (pullupOn[g]),
            .inputEnable         (inputEnable[g]),
            .syncIn              (syncIn[g])
         );
      end
   endgenerate

   // clock pin bypasses reset while fused
   assign clkoActive = clockOutFuse;
   always_comb begin
      padOut = cellOut;
      padOe  = cellOe;
      if (clkoActive) begin
         padOut[`PBAMUX_PIN_DIVIDED_CLOCK_OUT] = dividedClock;
         padOe[`PBAMUX_PIN_DIVIDED_CLOCK_OUT]  = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         slaveSel_ff <= 1'b0;
      end else begin
         slaveSel_ff <= spiSlave & ~syncIn[`PBAMUX_PIN_SSEL];
      end
   end
   assign spiSlaveSelected = slaveSel_ff;

   // Peripheral inputs from synchronised pads
   assign pinIn           = syncIn;
   assign sckIn           = syncIn[`PBAMUX_PIN_SCK];
   assign spiMasterDataIn = syncIn[`PBAMUX_PIN_MISO];
   assign spiSlaveDataIn  = syncIn[`PBAMUX_PIN_MOSI];
   assign timer3CaptureIn = syncIn[`PBAMUX_PIN_MOSI];
   assign extIrq2In       = syncIn[`PBAMUX_PIN_IRQ2];
   assign timer1CountIn   = syncIn[`PBAMUX_PIN_DIVIDED_CLOCK_OUT];
   assign timer0CountIn   = syncIn[`PBAMUX_PIN_XCK];
   // USART clock gated by sync mode
   assign usart0ExtClockIn = usart0SyncMode & ~dirBits[0] & syncIn[`PBAMUX_PIN_XCK];
   assign usart0ClockDrive = usart0SyncMode & dirBits[0];
   assign pinChangeSrc = syncIn;
endmodule

// *** tb/pbamux_monitor.sv ***
`timescale 1ns/10ps
// Port-level checks of the port B mux
module pbamux_monitor
   import pbamux_pkg::*;
(
   input wire logic                   clk,
   input wire logic                   rst,
   input wire logic [7:0]             dirBits,
   input wire logic [7:0]             outBits,
   input wire logic                   pullupGlobalDisable,
   input wire logic                   timer0CmpAEnable,
   input wire logic                   timer0CmpAOut,
   input wire logic                   clockOutFuse,
   input wire logic                   dividedClock,
   input wire logic [7:0]             padIn,
   input wire logic [7:0]             padOut,
   input wire logic [7:0]             padOe,
   input wire logic [7:0]             pullupOn,
   input wire logic [7:0]             inputEnable,
   input wire logic [15:8]            pinChangeSrc,
   input wire pbamux_pkg::pbamux_spi_t spiMode
);
   import pbamux_pkg::*;
   default clocking cb @(posedge clk); endclocking
   // Pin-level relations
   a_plain_pin: assert property (disable iff (rst) !$past(rst) |->
      padOe[2] == $past(dirBits[2]) && padOut[2] == $past(outBits[2]))
      else $error("pin2 not a plain port bit");
   a_cmp_value: assert property (disable iff (rst) $past(timer0CmpAEnable && !rst) |->
      padOut[3] == $past(timer0CmpAOut)) else $error("pin3 compare value lost");
   a_slave_inputs: assert property (disable iff (rst) spiMode == PBAMUX_SPI_SLAVE |=>
      padOe[7:4] ==? 4'b0?00) else $error("slave pins not forced input");
   a_master_miso: assert property (disable iff (rst) spiMode == PBAMUX_SPI_MASTER |=>
      !padOe[6]) else $error("master data-in pin driven");
   a_master_sck: assert property (disable iff (rst) spiMode == PBAMUX_SPI_MASTER |=>
      padOe[7] == $past(dirBits[7])) else $error("master clock pin direction wrong");
   a_clock_out: assert property (clockOutFuse |->
      padOe[1] && padOut[1] == dividedClock) else $error("divided clock missing on pin1");
   a_forced_pullup: assert property (disable iff (rst)
      spiMode == PBAMUX_SPI_SLAVE && !padOe[7] |-> pullupOn[7] == (outBits[7] && !pullupGlobalDisable))
      else $error("forced pin pull-up wrong");
   a_pin_change: assert property (disable iff (rst) !$past(rst) && !$past(rst, 2) |->
      pinChangeSrc == ($past(padIn, 2) & inputEnable)) else $error("pin-change source mismatch");
   // Main scenarios reached
   c_slave: cover property (spiMode == PBAMUX_SPI_SLAVE);
   c_master: cover property (spiMode == PBAMUX_SPI_MASTER);
   c_fuse_reset: cover property (clockOutFuse && rst);
endmodule
bind pbamux_port_b pbamux_monitor mon (.clk, .rst, .dirBits, .outBits, .pullupGlobalDisable,
   .timer0CmpAEnable, .timer0CmpAOut, .clockOutFuse, .dividedClock, .padIn, .padOut, .padOe,
   .pullupOn, .inputEnable, .pinChangeSrc, .spiMode);

// *** tb/pbamux_pad_model.sv ***
`timescale 1ns/10ps
// Pads of port B with the far-side drivers behind them
module pbamux_pad_model (
   input  wire logic [7:0] padOut,
   input  wire logic [7:0] padOe,
   input  wire logic [7:0] pullupOn,
   input  wire logic [7:0] extLevel,
   input  wire logic [7:0] extDrive,
   output logic [7:0]      padIn
);
   // Driven pad, then far side, then pull-up, else a floating level
   // pull-up holds a released pad
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (padOe[i]) padIn[i] = padOut[i];
         else if (extDrive[i]) padIn[i] = extLevel[i];
         else if (pullupOn[i]) padIn[i] = 1'b1;
         else padIn[i] = ~padOut[i]; // Floating pad drifts off
      end
   end
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/10ps
// Self-checking bench of the port B mux
module testbench;
   import pbamux_pkg::*;
`define CHK(n, e, a) begin nTests++; if ((a) !== (e)) begin fails++; \
   $display("mismatch %s exp %h got %h", n, e, a); end end
   logic clk = 0, rst = 1, pullupGlobalDisable = 0, sleepInputDisable = 0;
   logic serialIfEnable = 0, serialIfMasterSel = 0, sckOut = 0, spiSlaveDataOut = 0;
   logic spiMasterDataOut = 0, timer3CmpBOut = 0, timer3CmpBEnable = 0, timer3CmpAOut = 0;
   logic timer3CmpAEnable = 0, timer0CmpBOut = 0, timer0CmpBEnable = 0, timer0CmpAOut = 0;
   logic timer0CmpAEnable = 0, extIrq2Enable = 0, pinChangeGroup1En = 0, clockOutFuse = 0;
   logic dividedClock = 0, usart0SyncMode = 0, usart0ClockOut = 0;
   logic [7:0] dirBits = 8'h00, outBits = 8'h00, pinChangeMask = 8'h00;
   logic [7:0] extLevel = 8'h00, extDrive = 8'h00;
   logic [7:0] padIn, padOut, padOe, pullupOn, inputEnable, pinIn;
   logic sckIn, spiMasterDataIn, spiSlaveDataIn, spiSlaveSelected, timer3CaptureIn;
   logic extIrq2In, timer1CountIn, timer0CountIn, usart0ExtClockIn, usart0ClockDrive;
   logic [15:8] pinChangeSrc;
   pbamux_spi_t spiMode;
   int fails = 0, nTests = 0;
   // Device under test and its pads
   pbamux_port_b uut (.clk, .rst, .dirBits, .outBits, .pullupGlobalDisable, .sleepInputDisable,
      .serialIfEnable, .serialIfMasterSel, .sckOut, .spiSlaveDataOut, .spiMasterDataOut,
      .timer3CmpBOut, .timer3CmpBEnable, .timer3CmpAOut, .timer3CmpAEnable, .timer0CmpBOut,
      .timer0CmpBEnable, .timer0CmpAOut, .timer0CmpAEnable, .extIrq2Enable, .pinChangeMask,
      .pinChangeGroup1En, .clockOutFuse, .dividedClock, .usart0SyncMode, .usart0ClockOut,
      .padIn, .padOut, .padOe, .pullupOn, .inputEnable, .pinIn, .sckIn, .spiMasterDataIn,
      .spiSlaveDataIn, .spiSlaveSelected, .spiMode, .timer3CaptureIn, .extIrq2In,
      .timer1CountIn, .timer0CountIn, .usart0ExtClockIn, .usart0ClockDrive, .pinChangeSrc);
   pbamux_pad_model pads (.padOut, .padOe, .pullupOn, .extLevel, .extDrive, .padIn);
   // Clocks
   initial forever #20 clk = ~clk;
   always @(negedge clk) dividedClock <= ~dividedClock;
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic closeOut;
      if (fails == 0 && nTests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Plain port bits and the input functions
   task automatic plainPort;
      dirBits = 8'hF0; outBits = 8'hA5; extDrive = 8'h0F; extLevel = 8'h06;
      wt(3);
      `CHK("padOe", 8'hF0, padOe)
      `CHK("padOut", 4'hA, padOut[7:4])
      `CHK("pinChangeSrc", 4'h6, pinChangeSrc[11:8])
      `CHK("timer0CountIn", 1'b0, timer0CountIn)
      `CHK("timer1CountIn", 1'b1, timer1CountIn)
      `CHK("extIrq2In", 1'b1, extIrq2In)
      `CHK("pinIn", 8'hA6, pinIn)
      `CHK("pullupOn", 8'h05, pullupOn)
      // Sleep with input-enable overrides and pull-ups disabled
      sleepInputDisable = 1;
      pinChangeMask = 8'h81;
      pinChangeGroup1En = 1;
      extIrq2Enable = 1;
      pullupGlobalDisable = 1;
      wt(3);
      `CHK("inputEnable", 8'h85, inputEnable)
      `CHK("pinIn sleep", 8'h84, pinIn)
      `CHK("pullupOn off", 8'h00, pullupOn)
      pinChangeGroup1En = 0;
      wt(1);
      `CHK("inputEnable irq2", 8'h04, inputEnable)
      sleepInputDisable = 0;
      pinChangeMask = 8'h00;
      extIrq2Enable = 0;
      pullupGlobalDisable = 0;
      extDrive = 8'h00;
   endtask
   // Compare outputs with software-set directions
   task automatic compareOut;
      dirBits = 8'hD8; outBits = 8'h00;
      {timer3CmpBEnable, timer3CmpAEnable, timer0CmpBEnable, timer0CmpAEnable} = 4'hF;
      {timer3CmpBOut, timer3CmpAOut, timer0CmpBOut, timer0CmpAOut} = 4'hF;
      wt(2);
      `CHK("padOut cmp", 8'hD8, padOut & 8'hD8)
      `CHK("padOut pin7", 1'b1, padOut[7])
      {timer3CmpBEnable, timer3CmpAEnable, timer0CmpBEnable, timer0CmpAEnable} = 4'h0;
   endtask
   // Serial interface as slave, then as master
   task automatic spiRoles;
      dirBits = 8'hFF; outBits = 8'h80; serialIfEnable = 1; serialIfMasterSel = 0;
      wt(3);
      `CHK("spiMode", PBAMUX_SPI_SLAVE, spiMode)
      `CHK("padOe slave", 8'h00, padOe & 8'hB0)
      `CHK("padOe pin6", 1'b1, padOe[6])
      `CHK("pullupOn", 1'b1, pullupOn[7])
      extDrive = 8'h30; extLevel = 8'h20;
      wt(5);
      `CHK("spiSlaveSelected", 1'b1, spiSlaveSelected)
      `CHK("timer3CaptureIn", 1'b1, timer3CaptureIn)
      `CHK("spiSlaveDataIn", 1'b1, spiSlaveDataIn)
      `CHK("sckIn", 1'b1, sckIn)
      extLevel = 8'h30;
      wt(5);
      `CHK("spiSlaveSelected", 1'b0, spiSlaveSelected)
      extDrive = 8'h40; extLevel = 8'h40; sckOut = 1; serialIfMasterSel = 1;
      wt(5);
      `CHK("padOe pin6", 1'b0, padOe[6])
      `CHK("padOe pin7", 1'b1, padOe[7])
      `CHK("padOut sck", 1'b1, padOut[7])
      `CHK("spiMasterDataIn", 1'b1, spiMasterDataIn)
      extDrive = 8'h00; sckOut = 0;
      serialIfEnable = 0;
   endtask
   // Divided clock on pin1, through a reset
   task automatic clockOut;
      dirBits = 8'h00; outBits = 8'h00; clockOutFuse = 1; rst = 1;
      wt(2);
      repeat (2) begin
         @(posedge clk);
         #1;
         `CHK("padOe pin1", 1'b1, padOe[1])
         `CHK("padOut pin1", dividedClock, padOut[1])
      end
      wt(1);
      rst = 0;
      clockOutFuse = 0;
   endtask
   // USART clock direction and mode
   task automatic usartClock;
      usart0SyncMode = 1; dirBits = 8'h01; usart0ClockOut = 1;
      wt(3);
      `CHK("usart0ClockDrive", 1'b1, usart0ClockDrive)
      `CHK("padOut pin0", 1'b1, padOut[0])
      dirBits = 8'h00; extDrive = 8'h01; extLevel = 8'h01;
      wt(3);
      `CHK("usart0ClockDrive", 1'b0, usart0ClockDrive)
      `CHK("usart0ExtClockIn", 1'b1, usart0ExtClockIn)
      usart0SyncMode = 0; dirBits = 8'h01;
      wt(3);
      `CHK("usart0ClockDrive", 1'b0, usart0ClockDrive)
      `CHK("padOut pin0 async", 1'b0, padOut[0])
      extDrive = 8'h00;
   endtask
   // Main sequence
   initial begin
      wt(20);
      rst = 0;
      wt(1);
      plainPort();
      compareOut();
      spiRoles();
      clockOut();
      usartClock();
      closeOut();
   end
endmodule
